/* pkg/ec_regs.svh */
`ifndef EC_REGS_SVH
`define EC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EC_ADDR_LINE_HI  8'h23
`define EC_ADDR_LINE_LO  8'h24
`define EC_ADDR_SHARE_HI 8'h25
`define EC_ADDR_PATH_LO  8'h26
`define EC_ADDR_MF_LO    8'h27
`define EC_ADDR_EV_MASK  8'h6F
`define EC_ADDR_AL_MASK  8'h7F

// ----------------------------------------
// Reset values and field layout
// ----------------------------------------
`define EC_MASK_RESET  8'h00
`define EC_RD_UNMAPPED 8'h00
`define EC_LINE_W      16
`define EC_PATH_W      12
`define EC_MF_W        12

// ----------------------------------------
// Timing
// ----------------------------------------
`define EC_CLK_KHZ       25000
`define EC_SEC_SHORT_MS  999
`define EC_SEC_LONG_MS   1002
`define EC_FAST_MS       42
`define EC_MS_TO_CYC(ms) ((ms) * `EC_CLK_KHZ)
`define EC_TMR_W         25

`endif

/* pkg/ec_pkg.sv */
`include "ec_regs.svh"

package ec_pkg;

  typedef enum logic [1:0] {EC_PH_FIRST, EC_PH_SECOND, EC_PH_LONG} ec_phase_t;

  typedef struct packed {
    logic [`EC_TMR_W-1:0] secCnt;
    ec_phase_t            phase;
    logic [`EC_TMR_W-1:0] fastCnt;
    logic                 tickSec;
    logic                 tickFast;
  } ec_timer_t;

  typedef struct packed {
    logic [7:0] alarmMask;
    logic [7:0] eventMask;
    logic [7:0] rdData;
    logic       irq;
  } ec_regs_t;

endpackage : ec_pkg

/* design/ec_sat_counter.sv */
`timescale 1ns/10ps
`include "ec_regs.svh"

module ec_sat_counter
  import ec_pkg::*;
#(
  parameter int WIDTH = `EC_PATH_W
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic             countInc,
  input  wire logic             update,
  output logic      [WIDTH-1:0] count,
  output logic      [WIDTH-1:0] snapshot
);

  typedef struct packed {
    logic [WIDTH-1:0] acc;
    logic [WIDTH-1:0] snap;
  } ec_cnt_t;

  ec_cnt_t state_reg;
  ec_cnt_t state_next;

  // ----------------------------------------
  // Accumulate, saturate and hand over
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (update) begin
      state_next.snap = state_reg.acc;
      state_next.acc  = countInc ? WIDTH'(1) : '0;
    end else if (countInc && (state_reg.acc != {WIDTH{1'b1}})) begin
      state_next.acc = state_reg.acc + WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign count    = state_reg.acc;
  assign snapshot = state_reg.snap;

endmodule : ec_sat_counter

/* design/ec_interval_timer.sv */
`timescale 1ns/10ps
`include "ec_regs.svh"

module ec_interval_timer
  import ec_pkg::*;
#(
  parameter int SEC_SHORT_CYC = `EC_MS_TO_CYC(`EC_SEC_SHORT_MS),
  parameter int SEC_LONG_CYC  = `EC_MS_TO_CYC(`EC_SEC_LONG_MS),
  parameter int FAST_CYC      = `EC_MS_TO_CYC(`EC_FAST_MS)
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  output logic      tickSec,
  output logic      tickFast
);

  ec_timer_t            state_reg;
  ec_timer_t            state_next;
  logic [`EC_TMR_W-1:0] secLast;

  // ----------------------------------------
  // Second pattern and fast period
  // ----------------------------------------
  always_comb begin
    state_next          = state_reg;
    state_next.tickSec  = 1'b0;
    state_next.tickFast = 1'b0;
    secLast = (state_reg.phase == EC_PH_LONG) ? `EC_TMR_W'(SEC_LONG_CYC - 1)
                                              : `EC_TMR_W'(SEC_SHORT_CYC - 1);
    if (state_reg.secCnt == secLast) begin
      state_next.secCnt  = '0;
      state_next.tickSec = 1'b1;
      case (state_reg.phase)
        EC_PH_FIRST:  state_next.phase = EC_PH_SECOND;
        EC_PH_SECOND: state_next.phase = EC_PH_LONG;
        EC_PH_LONG:   state_next.phase = EC_PH_FIRST;
        default:      state_next.phase = EC_PH_FIRST;
      endcase
    end else begin
      state_next.secCnt = state_reg.secCnt + `EC_TMR_W'(1);
    end
    if (state_reg.fastCnt == `EC_TMR_W'(FAST_CYC - 1)) begin
      state_next.fastCnt  = '0;
      state_next.tickFast = 1'b1;
    end else begin
      state_next.fastCnt = state_reg.fastCnt + `EC_TMR_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= '{secCnt: '0, phase: EC_PH_FIRST, fastCnt: '0,
                     tickSec: 1'b0, tickFast: 1'b0};
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign tickSec  = state_reg.tickSec;
  assign tickFast = state_reg.tickFast;

endmodule : ec_interval_timer

/* design/ec_error_counters.sv */
`timescale 1ns/10ps
`include "ec_regs.svh"

// How it works
// - Alarm mask register gates eight alarm flags.
// - Event mask register gates eight event flags.
// - Update every second, or 42 ms when selected.
// - Readable counts hold previous interval until update.
// - Counters saturate at maximum, never wrap.
// - Line count 16 bits, high then low byte.
// - Line count content follows zeros and B8ZS settings.
// - Line counter runs during sync loss.
// - ESF mode counts CRC6 errors, Fs ignored.
// - D4 counts Ft errors, Fs when enabled.
// - Path counter halts during sync loss.
// - Path high nibble in shared byte low.
// - Mode one counts multiframe edges only during sync loss.
// - Mode zero counts pattern errors while synced.
// - Multiframe high nibble in shared byte high.
// - Second tick spacing 999, 999, 1002 ms.
// - Sync loss input gates the path and multiframe counters.
module ec_error_counters
  import ec_pkg::*;
#(
  parameter int SEC_SHORT_CYC = `EC_MS_TO_CYC(`EC_SEC_SHORT_MS),
  parameter int SEC_LONG_CYC  = `EC_MS_TO_CYC(`EC_SEC_LONG_MS),
  parameter int FAST_CYC      = `EC_MS_TO_CYC(`EC_FAST_MS)
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       updatePeriodSelect,
  input  wire logic       rxZeroSubstitutionEnable,
  input  wire logic       rxFramingModeSelect,
  input  wire logic       countExcessZerosEnable,
  input  wire logic       countFsErrorsEnable,
  input  wire logic       multiframeCounterMode,
  input  wire logic       lineBipolarViolation,
  input  wire logic       lineB8zsCodeWord,
  input  wire logic       lineZeroRun8,
  input  wire logic       lineZeroRun16,
  input  wire logic       rxCrc6Error,
  input  wire logic       rxFtError,
  input  wire logic       rxFsError,
  input  wire logic       rxFpsError,
  input  wire logic       rxMultiframeEdge,
  input  wire logic       rxFrameLoss,
  input  wire logic [7:0] alarmStatus,
  input  wire logic [7:0] eventStatus,
  output logic            interruptOut,
  output logic            oneHzTick
);

  ec_regs_t              state_reg;
  ec_regs_t              state_next;

  logic                  tickSec;
  logic                  tickFast;
  logic                  update;

  logic                  lineInc;
  logic                  pathInc;
  logic                  mfInc;
  logic                  zeroRunHit;

  logic [`EC_LINE_W-1:0] lineCount;
  logic [`EC_LINE_W-1:0] lineSnap;
  logic [`EC_PATH_W-1:0] pathCount;
  logic [`EC_PATH_W-1:0] pathSnap;
  logic [`EC_MF_W-1:0]   mfCount;
  logic [`EC_MF_W-1:0]   mfSnap;

  // ----------------------------------------
  // Update timing
  // ----------------------------------------
  ec_interval_timer #(
    .SEC_SHORT_CYC (SEC_SHORT_CYC),
    .SEC_LONG_CYC  (SEC_LONG_CYC),
    .FAST_CYC      (FAST_CYC)
  ) u_timer (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .tickSec  (tickSec),
    .tickFast (tickFast)
  );

  assign update    = updatePeriodSelect ? tickFast : tickSec;
  assign oneHzTick = tickSec;

  // ----------------------------------------
  // Count qualification
  // ----------------------------------------
  always_comb begin
    zeroRunHit = rxZeroSubstitutionEnable ? lineZeroRun8 : lineZeroRun16;
    lineInc    = (lineBipolarViolation
                  && !(rxZeroSubstitutionEnable && lineB8zsCodeWord))
                 || (countExcessZerosEnable && zeroRunHit);
    if (rxFrameLoss) begin
      pathInc = 1'b0;
    end else if (rxFramingModeSelect) begin
      pathInc = rxCrc6Error;
    end else begin
      pathInc = rxFtError || (countFsErrorsEnable && rxFsError);
    end
    if (multiframeCounterMode) begin
      mfInc = rxMultiframeEdge && rxFrameLoss;
    end else if (rxFrameLoss) begin
      mfInc = 1'b0;
    end else begin
      mfInc = rxFramingModeSelect ? rxFpsError : rxFtError;
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  ec_sat_counter #(
    .WIDTH (`EC_LINE_W)
  ) u_line_cnt (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .countInc (lineInc),
    .update   (update),
    .count    (lineCount),
    .snapshot (lineSnap)
  );

  ec_sat_counter #(
    .WIDTH (`EC_PATH_W)
  ) u_path_cnt (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .countInc (pathInc),
    .update   (update),
    .count    (pathCount),
    .snapshot (pathSnap)
  );

  ec_sat_counter #(
    .WIDTH (`EC_MF_W)
  ) u_mf_cnt (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .countInc (mfInc),
    .update   (update),
    .count    (mfCount),
    .snapshot (mfSnap)
  );

  // ----------------------------------------
  // Register port and interrupt
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (regWrEn && (regAddr == `EC_ADDR_AL_MASK)) begin
      state_next.alarmMask = regWrData;
    end
    if (regWrEn && (regAddr == `EC_ADDR_EV_MASK)) begin
      state_next.eventMask = regWrData;
    end
    if (regRdEn) begin
      case (regAddr)
        `EC_ADDR_LINE_HI:  state_next.rdData = lineSnap[15:8];
        `EC_ADDR_LINE_LO:  state_next.rdData = lineSnap[7:0];
        `EC_ADDR_SHARE_HI: state_next.rdData = {mfSnap[11:8], pathSnap[11:8]};
        `EC_ADDR_PATH_LO:  state_next.rdData = pathSnap[7:0];
        `EC_ADDR_MF_LO:    state_next.rdData = mfSnap[7:0];
        `EC_ADDR_EV_MASK:  state_next.rdData = state_reg.eventMask;
        `EC_ADDR_AL_MASK:  state_next.rdData = state_reg.alarmMask;
        default:           state_next.rdData = `EC_RD_UNMAPPED;
      endcase
    end
    state_next.irq = |(alarmStatus & state_reg.alarmMask)
                     || |(eventStatus & state_reg.eventMask);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= '{alarmMask: `EC_MASK_RESET, eventMask: `EC_MASK_RESET,
                     rdData: `EC_RD_UNMAPPED, irq: 1'b0};
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign regRdData    = state_reg.rdData;
  assign interruptOut = state_reg.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking ec_cb @(posedge sys_clk);
  endclocking

  default disable iff (sys_rst);

  a_alarm_mask_write: assert property (
    clkEn && regWrEn && (regAddr == `EC_ADDR_AL_MASK)
    |=> state_reg.alarmMask == $past(regWrData))
    else $error("Alarm mask write not taken.");

  a_event_mask_read: assert property (
    clkEn && regRdEn && (regAddr == `EC_ADDR_EV_MASK) && !regWrEn
    |=> regRdData == state_reg.eventMask)
    else $error("Event mask read back wrong.");

  a_update_select: assert property (
    clkEn && (updatePeriodSelect ? tickFast : tickSec)
    |=> lineSnap == $past(lineCount))
    else $error("Selected period did not update counts.");

  a_snap_stable: assert property (
    !(clkEn && update) |=> $stable(lineSnap) && $stable(pathSnap) && $stable(mfSnap))
    else $error("Readable count changed between updates.");

  a_line_saturate: assert property (
    clkEn && !update && (lineCount == 16'hFFFF) |=> lineCount == 16'hFFFF)
    else $error("Line counter wrapped.");

  a_line_hi_read: assert property (
    clkEn && regRdEn && (regAddr == `EC_ADDR_LINE_HI) |=> regRdData == $past(lineSnap[15:8]))
    else $error("Line high byte read wrong.");

  a_b8zs_exclude: assert property (
    clkEn && !update && rxZeroSubstitutionEnable && lineB8zsCodeWord
    && !countExcessZerosEnable |=> $stable(lineCount))
    else $error("Substitution code word was counted.");

  a_line_in_loss: assert property (
    clkEn && !update && rxFrameLoss && lineBipolarViolation && !lineB8zsCodeWord
    && (lineCount != 16'hFFFF) |=> lineCount == $past(lineCount) + 16'h0001)
    else $error("Line counter halted during sync loss.");

  a_crc_count: assert property (
    clkEn && !update && rxFramingModeSelect && !rxFrameLoss && rxCrc6Error
    && (pathCount != 12'hFFF) |=> pathCount == $past(pathCount) + 12'h001)
    else $error("CRC6 error not counted.");

  a_path_hold_loss: assert property (
    clkEn && !update && rxFrameLoss |=> $stable(pathCount))
    else $error("Path counter moved during sync loss.");

  a_share_hi_read: assert property (
    clkEn && regRdEn && (regAddr == `EC_ADDR_SHARE_HI)
    |=> regRdData == {$past(mfSnap[11:8]), $past(pathSnap[11:8])})
    else $error("Shared high byte packed wrong.");

  a_mf_pattern_loss: assert property (
    clkEn && !update && !multiframeCounterMode && rxFrameLoss |=> $stable(mfCount))
    else $error("Pattern error counted during sync loss.");

  a_update_clear: assert property (
    clkEn && update
    |=> pathSnap == $past(pathCount) && pathCount == {11'h000, $past(pathInc)})
    else $error("Update lost or doubled an event.");

  a_irq_follow: assert property (
    clkEn && ((alarmStatus & state_reg.alarmMask) == 8'h00)
    && ((eventStatus & state_reg.eventMask) == 8'h00) |=> !interruptOut)
    else $error("Interrupt set with no enabled flag.");

  a_irq_raise: assert property (
    clkEn && (((alarmStatus & state_reg.alarmMask) != 8'h00)
    || ((eventStatus & state_reg.eventMask) != 8'h00)) |=> interruptOut)
    else $error("Enabled flag did not raise the interrupt.");

  a_line_lo_read: assert property (
    clkEn && regRdEn && (regAddr == `EC_ADDR_LINE_LO) |=> regRdData == $past(lineSnap[7:0]))
    else $error("Line low byte read wrong.");

  a_mf_lo_read: assert property (
    clkEn && regRdEn && (regAddr == `EC_ADDR_MF_LO) |=> regRdData == $past(mfSnap[7:0]))
    else $error("Multiframe low byte read wrong.");

  a_unmapped_read: assert property (
    clkEn && regRdEn
    && (regAddr inside {[8'h00:8'h22], [8'h28:8'h6E], [8'h70:8'h7E], [8'h80:8'hFF]})
    |=> regRdData == `EC_RD_UNMAPPED)
    else $error("Unmapped read returned data.");

  a_count_wr_refused: assert property (
    clkEn && regWrEn && (regAddr inside {[`EC_ADDR_LINE_HI:`EC_ADDR_MF_LO]})
    |=> $stable(state_reg.alarmMask) && $stable(state_reg.eventMask))
    else $error("Write to a count register changed a mask.");

  a_zero_run_count: assert property (
    clkEn && !update && countExcessZerosEnable && rxZeroSubstitutionEnable && lineZeroRun8
    && (lineCount != 16'hFFFF) |=> lineCount == $past(lineCount) + 16'h0001)
    else $error("Eight-zero run not counted.");

  a_fs_count: assert property (
    clkEn && !update && !rxFramingModeSelect && !rxFrameLoss && countFsErrorsEnable
    && rxFsError && (pathCount != 12'hFFF) |=> pathCount == $past(pathCount) + 12'h001)
    else $error("Fs error not counted in D4 mode.");

  a_esf_ignore_fs: assert property (
    clkEn && !update && rxFramingModeSelect && !rxCrc6Error |=> $stable(pathCount))
    else $error("Path counter moved without a CRC6 error.");

  a_path_saturate: assert property (
    clkEn && !update && (pathCount == 12'hFFF) |=> pathCount == 12'hFFF)
    else $error("Path counter wrapped.");

  a_mf_saturate: assert property (
    clkEn && !update && (mfCount == 12'hFFF) |=> mfCount == 12'hFFF)
    else $error("Multiframe counter wrapped.");

  a_mos_count: assert property (
    clkEn && !update && multiframeCounterMode && rxFrameLoss && rxMultiframeEdge
    && (mfCount != 12'hFFF) |=> mfCount == $past(mfCount) + 12'h001)
    else $error("Out-of-sync multiframe not counted.");

  a_mos_in_sync: assert property (
    clkEn && !update && multiframeCounterMode && !rxFrameLoss |=> $stable(mfCount))
    else $error("Multiframe counted while in sync.");

  a_mf_pattern_count: assert property (
    clkEn && !update && !multiframeCounterMode && !rxFrameLoss && !rxFramingModeSelect
    && rxFtError && (mfCount != 12'hFFF) |=> mfCount == $past(mfCount) + 12'h001)
    else $error("Ft pattern error not counted.");

  a_line_update_clear: assert property (
    clkEn && update
    |=> lineSnap == $past(lineCount) && lineCount == {15'h0000, $past(lineInc)})
    else $error("Line update lost or doubled an event.");

  a_tick_pulse: assert property (
    clkEn && oneHzTick |=> !oneHzTick)
    else $error("Second tick lasted more than one cycle.");

  a_clk_freeze: assert property (
    !clkEn |=> $stable(lineCount) && $stable(pathCount) && $stable(mfCount)
    && $stable(regRdData) && $stable(interruptOut) && $stable(oneHzTick))
    else $error("State moved while clock enable was low.");

  c_sec_tick: cover property (clkEn && tickSec);
  c_fast_update: cover property (clkEn && updatePeriodSelect && tickFast);
  c_line_sat: cover property (clkEn && update && (lineCount == 16'hFFFF));
  c_irq_rise: cover property (!interruptOut ##1 interruptOut);
  c_mos_count: cover property (clkEn && multiframeCounterMode && mfInc);

endmodule : ec_error_counters

/* bench/tb_top.sv */
`timescale 1ns/10ps
`include "ec_regs.svh"

module tb_top
  import ec_pkg::*;
;
  // ----------------------------------------
  // Signals and design instance
  // ----------------------------------------
  localparam int S = 4200;
  localparam int L = 4203;
  localparam int F = 50;

  logic       sys_clk;
  logic       sys_rst;
  logic       clkEn;
  logic [7:0] regAddr;
  logic       regWrEn;
  logic [7:0] regWrData;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic [5:0] mode;
  logic [9:0] evt;
  logic [7:0] alarmStatus;
  logic [7:0] eventStatus;
  logic       interruptOut;
  logic       oneHzTick;
  int         num_errors;
  int         cmp_count;
  int         seed;
  int         cyc;
  int         gap;
  int         tk;
  int         la;
  int         pa;
  int         ma;

  ec_error_counters #(
    .SEC_SHORT_CYC(S),
    .SEC_LONG_CYC (L),
    .FAST_CYC     (F)
  ) u_ec_error_counters (
    .sys_clk                 (sys_clk),
    .sys_rst                 (sys_rst),
    .clkEn                   (clkEn),
    .regAddr                 (regAddr),
    .regWrEn                 (regWrEn),
    .regWrData               (regWrData),
    .regRdEn                 (regRdEn),
    .regRdData               (regRdData),
    .updatePeriodSelect      (mode[0]),
    .rxZeroSubstitutionEnable(mode[1]),
    .rxFramingModeSelect     (mode[2]),
    .countExcessZerosEnable  (mode[3]),
    .countFsErrorsEnable     (mode[4]),
    .multiframeCounterMode   (mode[5]),
    .lineBipolarViolation    (evt[0]),
    .lineB8zsCodeWord        (evt[1]),
    .lineZeroRun8            (evt[2]),
    .lineZeroRun16           (evt[3]),
    .rxCrc6Error             (evt[4]),
    .rxFtError               (evt[5]),
    .rxFsError               (evt[6]),
    .rxFpsError              (evt[7]),
    .rxMultiframeEdge        (evt[8]),
    .rxFrameLoss             (evt[9]),
    .alarmStatus             (alarmStatus),
    .eventStatus             (eventStatus),
    .interruptOut            (interruptOut),
    .oneHzTick               (oneHzTick)
  );

  // ----------------------------------------
  // Clock, cycle count and tick spacing
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= sys_rst ? 0 : cyc + int'(clkEn);
    if (sys_rst) begin
      gap = 0;
    end else if (clkEn) begin
      gap++;
      if (oneHzTick === 1'b1) begin
        if (tk > 0) chk("tickGap", ((tk % 3) == 2) ? L : S, gap);
        tk++;
        gap = 0;
      end
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd

  task automatic rdAll(input int l, input int p, input int m);
    logic [7:0]  d;
    logic [15:0] sl;
    logic [11:0] sp;
    logic [11:0] sm;
    sl = (l > 65535) ? 16'hFFFF : 16'(l);
    sp = (p > 4095) ? 12'hFFF : 12'(p);
    sm = (m > 4095) ? 12'hFFF : 12'(m);
    rd(8'h23, d);
    chk("lineHigh", sl[15:8], d);
    rd(8'h24, d);
    chk("lineLow", sl[7:0], d);
    rd(8'h25, d);
    chk("sharedHigh", {sm[11:8], sp[11:8]}, d);
    rd(8'h26, d);
    chk("pathLow", sp[7:0], d);
    rd(8'h27, d);
    chk("mfLow", sm[7:0], d);
  endtask : rdAll

  task automatic ev(input int n, input bit sat);
    logic [9:0] v;
    repeat (n) begin
      @(posedge sys_clk);
      v = 10'($random(seed));
      if (sat) v = (v | 10'h091) & 10'h1FF;
      evt <= v;
      la += (v[0] && !(mode[1] && v[1])) || (mode[3] && (mode[1] ? v[2] : v[3]));
      pa += !v[9] && (mode[2] ? v[4] : (v[5] || (mode[4] && v[6])));
      ma += mode[5] ? (v[9] && v[8]) : (!v[9] && (mode[2] ? v[7] : v[5]));
    end
    @(posedge sys_clk);
    evt <= '0;
  endtask : ev

  task automatic waitTick();
    int i;
    @(posedge sys_clk);
    for (i = 0; i < 5000 && oneHzTick !== 1'b1; i++) @(posedge sys_clk);
  endtask : waitTick

  task automatic waitMod(input int m);
    @(posedge sys_clk);
    while (cyc % F != m) @(posedge sys_clk);
  endtask : waitMod

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    #(50000 * 40);
    num_errors++;
    results();
  end

  initial begin
    logic [31:0] r;
    logic [7:0]  d;
    int          pl;
    int          pp;
    int          pm;
    seed = 66;
    {regAddr, regWrEn, regWrData, regRdEn, mode, evt} = '0;
    {alarmStatus, eventStatus, num_errors, cmp_count, tk} = '0;
    clkEn   = 1'b1;
    sys_rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h7F, d);
    chk("alarmMaskReset", 8'h00, d);
    rd(8'h6F, d);
    chk("eventMaskReset", 8'h00, d);
    rd(8'h10, d);
    chk("unmapped", 8'h00, d);
    wr(8'h23, 8'hFF);
    rdAll(0, 0, 0);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(8'h7F, 8'h5A);
    clkEn <= 1'b1;
    rd(8'h7F, d);
    chk("frozenMask", 8'h00, d);
    repeat (16) begin
      r = $random(seed);
      wr(8'h7F, r[7:0]);
      wr(8'h6F, r[15:8]);
      alarmStatus <= 8'h01 << r[18:16];
      eventStatus <= r[22] ? 8'h01 << r[21:19] : 8'h00;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("irq", r[r[18:16]] || (r[22] && r[8 + r[21:19]]), interruptOut);
      rd(8'h7F, d);
      chk("alarmMask", r[7:0], d);
    end
    alarmStatus <= 8'h00;
    eventStatus <= 8'h00;
    {pl, pp, pm} = '0;
    waitTick();
    for (int k = 0; k < 7; k++) begin
      {la, pa, ma} = '0;
      r = $random(seed);
      mode <= (k == 6) ? 6'b000100 : {r[4:0], 1'b0};
      ev((k == 6) ? 4100 : 30, k == 6);
      rdAll(pl, pp, pm);
      waitTick();
      repeat (2) @(posedge sys_clk);
      rdAll(la, pa, ma);
      {pl, pp, pm} = {la, pa, ma};
    end
    r = $random(seed);
    mode <= {r[4:0], 1'b1};
    repeat (3) begin
      waitMod(5);
      {la, pa, ma} = '0;
      ev(20, 1'b0);
      waitMod(10);
      rdAll(la, pa, ma);
    end
    results();
  end
endmodule : tb_top
